// ===== logic/ssp_pkg.sv
// Function
// - Address mode slave checks first character
// - Match sets receive flag, enables data out
// - Address match can wake sleeping system
// - Mismatch ignores whole transaction until deselect
// - Nine-bit characters compare low eight bits
// - Without preload, old shift contents go first
// - Preload one character while select high
// - Later character waits in transmit holding
// - Preload bit set enables preload behaviour
// - Daisy chain shifts n characters per transaction
// - Same input and output pad loops back
// - Three interrupt sources, each can wake a master
// - Enable set and clear registers, one-bit writes
// - Request while flag and enable both set
// - One request line, flags name the source
// - Master keeping clock asleep keeps core running
// - Master otherwise stops after current transaction
// - Slave keeps only receive wake, else drops
// - Reset, enable, receiver bits write synchronised
// - Data address writes transmit, reads receive
// - Mode two slave, mode three master
package ssp_pkg;

  // ************************************************
  // Register offsets
  // ************************************************
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_DEBUG = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0A;
  localparam logic [7:0] OFS_IEN_CLR = 8'h0C;
  localparam logic [7:0] OFS_IEN_SET = 8'h0D;
  localparam logic [7:0] OFS_FLAGS = 8'h0E;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;

  // ************************************************
  // Field positions and values
  // ************************************************
  localparam int CA_SOFT_RESET = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_MODE = 2;
  localparam int CA_KEEP = 7;
  localparam int CA_OUTPUT_PAD_SELECT = 16;
  localparam int CA_INPUT_PAD_SELECT = 20;
  localparam int CA_FRAME_FORMAT_SELECT = 24;
  localparam int CA_CPHA = 28;
  localparam int CA_CPOL = 29;
  localparam int CA_DORD = 30;
  localparam int CB_CHAR_SIZE = 0;
  localparam int CB_PRELOAD = 6;
  localparam int CB_HWSEL = 13;
  localparam int CB_RXON = 17;
  localparam int FL_DRE = 0;
  localparam int FL_TXC = 1;
  localparam int FL_RXC = 2;
  localparam int ST_OVF = 2;
  localparam int ST_SYNC = 15;
  localparam int AD_MASK = 16;
  localparam int DBG_HALT = 0;

  localparam logic [31:0] CTRL_A_WMASK = 32'h7F33_019C;
  localparam logic [31:0] CTRL_B_WMASK = 32'h0000_2047;
  localparam logic [31:0] ADDR_WMASK = 32'h00FF_00FF;

  localparam logic [2:0] MODE_SLAVE = 3'h2;
  localparam logic [2:0] MODE_MASTER = 3'h3;
  localparam logic [3:0] FRAME_FORMAT_SELECT_ADDR = 4'h2;
  localparam logic [2:0] CHAR_SIZE_9 = 3'h1;

  // Pad index per selector value, entry 0 in the low bits
  localparam logic [7:0] DO_PAD_LUT = 8'h38;
  localparam logic [7:0] SCK_PAD_LUT = 8'hDD;
  localparam logic [7:0] SS_PAD_LUT = 8'h66;

  // ************************************************
  // Reset values and timing
  // ************************************************
  localparam logic [8:0] SHIFT_RESET = 9'h000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SYNC_TIME_NS = 15;
  localparam int SYNC_CYCLES =
    (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_LOAD = 2'(SYNC_CYCLES);

  typedef enum logic [1:0] {XF_IDLE, XF_ADDR, XF_DATA, XF_IGNORE} ssp_xfer_t;
  typedef enum logic {M_IDLE, M_RUN} ssp_mst_t;

endpackage

// ===== logic/ssp_sync2.sv
module ssp_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ===== logic/ssp_top.sv
module ssp_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe,
  input wire logic sleep_req,
  input wire logic debug_halt,
  output logic irq,
  output logic wake_req,
  output logic core_clk_req
);

  // ************************************************
  // Registers and decode
  // ************************************************
  logic [31:0] ctrl_a_reg, ctrl_b_reg, addr_reg;
  logic [7:0] baud_reg;
  logic dbg_reg;
  logic [2:0] ien_reg;
  logic flag_txc_reg, overflow_reg;
  logic [8:0] tx_hold_reg, rx_hold_reg, shift_reg;
  logic tx_valid_reg, rx_valid_reg;
  logic enable_reg, rx_on_reg, pend_en_reg, pend_rxon_reg, pend_soft_reset_reg;
  logic [1:0] sync_cnt_reg;
  logic [3:0] pad_sync;
  ssp_pkg::ssp_xfer_t xfer_reg;
  ssp_pkg::ssp_mst_t mst_reg;
  logic [3:0] bit_cnt_reg;
  logic [4:0] edge_cnt_reg;
  logic [7:0] baud_cnt_reg;
  logic m_sck_reg, sck_prev_reg, preloaded_reg;

  logic wr_a, wr_b, wr_data, rd_data, sync_apply, soft_clr;
  logic [2:0] mode;
  logic is_slave, is_master, keep_running, cpol, cpha, dord, char9;
  logic preload_en, hw_sel, addr_mode;
  logic [1:0] do_pad, sck_pad, ss_pad, din_pad;
  logic ss_low, din, sck_now, sample_edge, sel_active, drop_rx;
  logic [3:0] nbits;
  logic char_done, addr_match, keep_char, rx_store, tx_take;
  logic preload_fire, master_load, m_tick, m_bound, do_bit, do_en;
  logic [8:0] shift_next, char_word;
  logic [2:0] flags;
  logic [3:0] pad_out_next, pad_oe_next;

  assign wr_a = reg_wr && reg_addr == ssp_pkg::OFS_CTRL_A;
  assign wr_b = reg_wr && reg_addr == ssp_pkg::OFS_CTRL_B;
  assign wr_data = reg_wr && reg_addr == ssp_pkg::OFS_DATA;
  assign rd_data = reg_rd && reg_addr == ssp_pkg::OFS_DATA;

  assign mode = ctrl_a_reg[ssp_pkg::CA_MODE +: 3];
  assign is_slave = enable_reg && mode == ssp_pkg::MODE_SLAVE;
  assign is_master = enable_reg && mode == ssp_pkg::MODE_MASTER;
  assign keep_running = ctrl_a_reg[ssp_pkg::CA_KEEP];
  assign cpol = ctrl_a_reg[ssp_pkg::CA_CPOL];
  assign cpha = ctrl_a_reg[ssp_pkg::CA_CPHA];
  assign dord = ctrl_a_reg[ssp_pkg::CA_DORD];
  assign char9 = ctrl_b_reg[ssp_pkg::CB_CHAR_SIZE +: 3] == ssp_pkg::CHAR_SIZE_9;
  assign preload_en = ctrl_b_reg[ssp_pkg::CB_PRELOAD];
  assign hw_sel = ctrl_b_reg[ssp_pkg::CB_HWSEL];
  assign addr_mode = is_slave &&
    ctrl_a_reg[ssp_pkg::CA_FRAME_FORMAT_SELECT +: 4] == ssp_pkg::FRAME_FORMAT_SELECT_ADDR;
  assign nbits = char9 ? 4'h9 : 4'h8;

  // ************************************************
  // Write synchronisation
  // ************************************************
  // Reset, enable and receiver bits take effect a few cycles late
  assign sync_apply = sync_cnt_reg == 2'h1;
  assign soft_clr = sync_apply && pend_soft_reset_reg;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_cnt_reg <= 2'h0;
      pend_en_reg <= 1'b0;
      pend_rxon_reg <= 1'b0;
      pend_soft_reset_reg <= 1'b0;
      enable_reg <= 1'b0;
      rx_on_reg <= 1'b0;
    end
    else
    begin
      if (wr_a || wr_b)
      begin
        sync_cnt_reg <= ssp_pkg::SYNC_LOAD;
        if (wr_a)
        begin
          pend_en_reg <= reg_wdata[ssp_pkg::CA_ENABLE];
          pend_soft_reset_reg <= reg_wdata[ssp_pkg::CA_SOFT_RESET];
        end
        if (wr_b)
          pend_rxon_reg <= reg_wdata[ssp_pkg::CB_RXON];
      end
      else if (sync_cnt_reg != 2'h0)
        sync_cnt_reg <= sync_cnt_reg - 2'h1;
      if (soft_clr && !(wr_a || wr_b))
      begin
        enable_reg <= 1'b0;
        rx_on_reg <= 1'b0;
        pend_en_reg <= 1'b0;
        pend_rxon_reg <= 1'b0;
        pend_soft_reset_reg <= 1'b0;
      end
      else if (sync_apply && !(wr_a || wr_b))
      begin
        enable_reg <= pend_en_reg;
        rx_on_reg <= pend_rxon_reg;
      end
    end
  end

  // ************************************************
  // Configuration registers
  // ************************************************
  // Enable-protected fields are frozen while the unit runs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_a_reg <= ssp_pkg::REG_RESET;
      ctrl_b_reg <= ssp_pkg::REG_RESET;
      addr_reg <= ssp_pkg::REG_RESET;
      baud_reg <= 8'h00;
      ien_reg <= 3'h0;
      dbg_reg <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == ssp_pkg::OFS_DEBUG)
        dbg_reg <= reg_wdata[ssp_pkg::DBG_HALT];
      if (soft_clr)
      begin
        ctrl_a_reg <= ssp_pkg::REG_RESET;
        ctrl_b_reg <= ssp_pkg::REG_RESET;
        addr_reg <= ssp_pkg::REG_RESET;
        baud_reg <= 8'h00;
        ien_reg <= 3'h0;
      end
      else
      begin
        if (wr_a && !enable_reg)
          ctrl_a_reg <= reg_wdata & ssp_pkg::CTRL_A_WMASK;
        if (wr_b && !enable_reg)
          ctrl_b_reg <= reg_wdata & ssp_pkg::CTRL_B_WMASK;
        if (reg_wr && reg_addr == ssp_pkg::OFS_ADDR && !enable_reg)
          addr_reg <= reg_wdata & ssp_pkg::ADDR_WMASK;
        if (reg_wr && reg_addr == ssp_pkg::OFS_BAUD && !enable_reg)
          baud_reg <= reg_wdata[7:0];
        if (reg_wr && reg_addr == ssp_pkg::OFS_IEN_SET)
          ien_reg <= ien_reg | reg_wdata[2:0];
        else if (reg_wr && reg_addr == ssp_pkg::OFS_IEN_CLR)
          ien_reg <= ien_reg & ~reg_wdata[2:0];
      end
    end
  end

  // ************************************************
  // Pads and clock edges
  // ************************************************
  ssp_sync2 #(.WIDTH(4)) u_pad_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  assign do_pad =
    ssp_pkg::DO_PAD_LUT[{ctrl_a_reg[ssp_pkg::CA_OUTPUT_PAD_SELECT +: 2], 1'b0} +: 2];
  assign sck_pad =
    ssp_pkg::SCK_PAD_LUT[{ctrl_a_reg[ssp_pkg::CA_OUTPUT_PAD_SELECT +: 2], 1'b0} +: 2];
  assign ss_pad =
    ssp_pkg::SS_PAD_LUT[{ctrl_a_reg[ssp_pkg::CA_OUTPUT_PAD_SELECT +: 2], 1'b0} +: 2];
  assign din_pad = ctrl_a_reg[ssp_pkg::CA_INPUT_PAD_SELECT +: 2];
  // Receiver reads the pad itself, so a shared pad loops back
  assign din = pad_sync[din_pad];
  assign ss_low = !pad_sync[ss_pad];
  assign sck_now = is_master ? m_sck_reg : pad_sync[sck_pad];
  assign sample_edge = sck_now != sck_prev_reg && sck_now == !(cpol ^ cpha);
  assign sel_active = (is_slave && ss_low) || mst_reg == ssp_pkg::M_RUN;
  assign drop_rx = is_slave && sleep_req && !keep_running;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sck_prev_reg <= 1'b0;
    else
      sck_prev_reg <= sck_now;
  end

  // ************************************************
  // Transaction state and shift engine
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      xfer_reg <= ssp_pkg::XF_IDLE;
    else if (!sel_active)
      xfer_reg <= ssp_pkg::XF_IDLE;
    else if (drop_rx)
      xfer_reg <= ssp_pkg::XF_IGNORE;
    else
      unique case (xfer_reg)
        ssp_pkg::XF_IDLE:
          xfer_reg <= addr_mode ? ssp_pkg::XF_ADDR : ssp_pkg::XF_DATA;
        ssp_pkg::XF_ADDR:
          if (char_done)
            xfer_reg <= addr_match ? ssp_pkg::XF_DATA :
              ssp_pkg::XF_IGNORE;
        ssp_pkg::XF_DATA, ssp_pkg::XF_IGNORE:
          xfer_reg <= xfer_reg;
      endcase
  end

  assign shift_next = dord ?
    (char9 ? {din, shift_reg[8:1]} : {1'b0, din, shift_reg[7:1]}) :
    (char9 ? {shift_reg[7:0], din} : {1'b0, shift_reg[6:0], din});
  assign do_bit = dord ? shift_reg[0] : (char9 ? shift_reg[8] : shift_reg[7]);
  assign char_done = sample_edge && xfer_reg != ssp_pkg::XF_IDLE &&
    bit_cnt_reg == nbits - 4'h1;
  assign char_word = char9 ? shift_next : {1'b0, shift_next[7:0]};
  // Ninth bit never takes part; masked bits are dont-care
  assign addr_match = ((shift_next[7:0] ^ addr_reg[7:0]) &
    ~addr_reg[ssp_pkg::AD_MASK +: 8]) == 8'h00;
  assign keep_char = xfer_reg == ssp_pkg::XF_DATA ||
    (xfer_reg == ssp_pkg::XF_ADDR && addr_match);
  assign rx_store = char_done && keep_char && rx_on_reg;
  assign preload_fire = is_slave && preload_en && !ss_low &&
    tx_valid_reg && !preloaded_reg;
  // Master reloads at each character boundary while data is queued
  assign tx_take = preload_fire || master_load ||
    (m_tick && m_bound && tx_valid_reg) ||
    (char_done && keep_char && tx_valid_reg && is_slave);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      bit_cnt_reg <= 4'h0;
    else if (xfer_reg == ssp_pkg::XF_IDLE || char_done)
      bit_cnt_reg <= 4'h0;
    else if (sample_edge)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end

  // Old contents leave first unless a character was preloaded
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      shift_reg <= ssp_pkg::SHIFT_RESET;
    else if (soft_clr)
      shift_reg <= ssp_pkg::SHIFT_RESET;
    else if (tx_take)
      shift_reg <= tx_hold_reg;
    else if (sample_edge && xfer_reg != ssp_pkg::XF_IDLE)
      shift_reg <= shift_next;
  end

  // One preload per idle period; a later write waits in holding
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      preloaded_reg <= 1'b0;
    else if (ss_low || !is_slave)
      preloaded_reg <= 1'b0;
    else if (preload_fire)
      preloaded_reg <= 1'b1;
  end

  // ************************************************
  // Master clock and select
  // ************************************************
  // Data in passes the pad synchroniser; keep the divider at 3 or more
  assign master_load = is_master && mst_reg == ssp_pkg::M_IDLE &&
    tx_valid_reg && !(sleep_req && !keep_running);
  assign m_tick = mst_reg == ssp_pkg::M_RUN && baud_cnt_reg == baud_reg &&
    !(dbg_reg && debug_halt);
  assign m_bound = edge_cnt_reg == {nbits, 1'b0};

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mst_reg <= ssp_pkg::M_IDLE;
      m_sck_reg <= 1'b0;
      edge_cnt_reg <= 5'h00;
      baud_cnt_reg <= 8'h00;
    end
    else if (!is_master)
    begin
      mst_reg <= ssp_pkg::M_IDLE;
      m_sck_reg <= cpol;
      edge_cnt_reg <= 5'h00;
      baud_cnt_reg <= 8'h00;
    end
    else
      unique case (mst_reg)
        ssp_pkg::M_IDLE:
        begin
          m_sck_reg <= cpol;
          edge_cnt_reg <= 5'h00;
          baud_cnt_reg <= 8'h00;
          if (master_load)
            mst_reg <= ssp_pkg::M_RUN;
        end
        ssp_pkg::M_RUN:
        begin
          baud_cnt_reg <= m_tick ? 8'h00 : baud_cnt_reg + 8'h01;
          if (m_tick && m_bound)
          begin
            edge_cnt_reg <= 5'h00;
            // Stay selected while more characters are queued
            if (!tx_valid_reg)
              mst_reg <= ssp_pkg::M_IDLE;
          end
          else if (m_tick)
          begin
            m_sck_reg <= !m_sck_reg;
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
          end
        end
      endcase
  end

  // ************************************************
  // Holding registers and flags
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_hold_reg <= 9'h000;
      tx_valid_reg <= 1'b0;
    end
    else if (soft_clr)
      tx_valid_reg <= 1'b0;
    else if (wr_data)
    begin
      tx_hold_reg <= reg_wdata[8:0];
      tx_valid_reg <= 1'b1;
    end
    else if (tx_take || (m_tick && m_bound && tx_valid_reg))
      tx_valid_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_hold_reg <= 9'h000;
      rx_valid_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end
    else if (soft_clr)
    begin
      rx_valid_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end
    else
    begin
      if (rx_store)
      begin
        rx_hold_reg <= char_word;
        rx_valid_reg <= 1'b1;
      end
      else if (rd_data)
        rx_valid_reg <= 1'b0;
      if (rx_store && rx_valid_reg && !rd_data)
        overflow_reg <= 1'b1;
      else if (!rx_on_reg || (reg_wr && reg_addr == ssp_pkg::OFS_STATUS &&
               reg_wdata[ssp_pkg::ST_OVF]))
        overflow_reg <= 1'b0;
    end
  end

  // Release after a kept transaction, or end of a master run
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_txc_reg <= 1'b0;
    else if (soft_clr)
      flag_txc_reg <= 1'b0;
    else if (xfer_reg == ssp_pkg::XF_DATA && !sel_active)
      flag_txc_reg <= 1'b1;
    else if (reg_wr && reg_addr == ssp_pkg::OFS_FLAGS &&
             reg_wdata[ssp_pkg::FL_TXC])
      flag_txc_reg <= 1'b0;
  end

  assign flags = {rx_valid_reg, flag_txc_reg, !tx_valid_reg};

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq <= |(flags & ien_reg);
      wake_req <= sleep_req && (is_master ? |(flags & ien_reg) :
        keep_running && flags[ssp_pkg::FL_RXC] &&
        ien_reg[ssp_pkg::FL_RXC]);
    end
  end

  assign core_clk_req = !sleep_req || keep_running ||
    mst_reg == ssp_pkg::M_RUN;

  // ************************************************
  // Pad drive and read data
  // ************************************************
  assign do_en = xfer_reg == ssp_pkg::XF_DATA;

  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      pad_out_next[p] = 1'b0;
      pad_oe_next[p] = 1'b0;
      if (2'(p) == do_pad)
      begin
        pad_out_next[p] = do_bit;
        pad_oe_next[p] = do_en;
      end
      else if (is_master && 2'(p) == sck_pad)
      begin
        pad_out_next[p] = m_sck_reg;
        pad_oe_next[p] = 1'b1;
      end
      else if (is_master && hw_sel && 2'(p) == ss_pad)
      begin
        pad_out_next[p] = mst_reg != ssp_pkg::M_RUN;
        pad_oe_next[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pad_out <= 4'h0;
      pad_oe <= 4'h0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      pad_out <= pad_out_next;
      pad_oe <= pad_oe_next;
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
        unique case (reg_addr)
          ssp_pkg::OFS_CTRL_A:
            reg_rdata <= ctrl_a_reg | {30'h0, pend_en_reg, pend_soft_reset_reg};
          ssp_pkg::OFS_CTRL_B:
            reg_rdata <= ctrl_b_reg | {14'h0, pend_rxon_reg, 17'h0};
          ssp_pkg::OFS_DEBUG: reg_rdata <= {31'h0, dbg_reg};
          ssp_pkg::OFS_BAUD: reg_rdata <= {24'h0, baud_reg};
          ssp_pkg::OFS_IEN_CLR, ssp_pkg::OFS_IEN_SET:
            reg_rdata <= {29'h0, ien_reg};
          ssp_pkg::OFS_FLAGS: reg_rdata <= {29'h0, flags};
          ssp_pkg::OFS_STATUS:
            reg_rdata <= {16'h0, sync_cnt_reg != 2'h0, 12'h0,
              overflow_reg, 2'h0};
          ssp_pkg::OFS_ADDR: reg_rdata <= addr_reg;
          ssp_pkg::OFS_DATA: reg_rdata <= {23'h0, rx_hold_reg};
          default: reg_rdata <= 32'h0000_0000;
        endcase
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ignore_no_store_a: assert property (
    xfer_reg == ssp_pkg::XF_IGNORE |-> !rx_store && !tx_take)
    else $error("ignored transaction stored data");
  match_sets_rxc_a: assert property (
    char_done && xfer_reg == ssp_pkg::XF_ADDR && addr_match && rx_on_reg
    |=> rx_valid_reg && xfer_reg == ssp_pkg::XF_DATA ##1 pad_oe[do_pad])
    else $error("address match did not raise receive flag");
  nomatch_ignores_a: assert property (
    char_done && xfer_reg == ssp_pkg::XF_ADDR && !addr_match && sel_active
    |=> xfer_reg == ssp_pkg::XF_IGNORE)
    else $error("mismatch not ignored");
  ninth_bit_free_a: assert property (
    char_done && char9 && shift_next[7:0] == addr_reg[7:0] |-> addr_match)
    else $error("ninth bit entered compare");
  preload_once_a: assert property (
    preload_fire |=> shift_reg == $past(tx_hold_reg) && !preload_fire)
    else $error("preload wrong or repeated");
  second_waits_a: assert property (
    preloaded_reg && !ss_low && wr_data |=> tx_valid_reg)
    else $error("second character lost from holding");
  irq_follows_a: assert property (
    (flags & ien_reg) == 3'h0 ##1 (flags & ien_reg) == 3'h0 |=> !irq)
    else $error("request without enabled flag");
  ien_set_a: assert property (
    reg_wr && reg_addr == ssp_pkg::OFS_IEN_SET && reg_wdata[2:0] == 3'h7
    && !soft_clr |=> ien_reg == 3'h7 ##1 irq == |$past(flags))
    else $error("enable set ignored");
  sync_pending_a: assert property (
    wr_a && !wr_b ##1 !(wr_a || wr_b) [*3]
    |=> sync_cnt_reg == 2'h0 &&
    enable_reg == ($past(pend_en_reg) && !$past(pend_soft_reset_reg)))
    else $error("synchronised write not applied in time");
  master_clock_a: assert property (
    mst_reg == ssp_pkg::M_RUN |-> core_clk_req)
    else $error("core clock stopped mid transaction");

  cover_match_c: cover property (
    xfer_reg == ssp_pkg::XF_ADDR ##1 xfer_reg == ssp_pkg::XF_DATA);
  cover_preload_c: cover property (preload_fire ##[1:200] ss_low);
  cover_master_c: cover property (
    mst_reg == ssp_pkg::M_RUN ##1 mst_reg == ssp_pkg::M_IDLE);
  cover_loop_c: cover property (rx_store && din_pad == do_pad);

endmodule

// ===== testbench/ssp_mst_model.sv
module ssp_mst_model (
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  // Released data line shows the inverse, never a stale bit
  task automatic sel(input logic on);
    ss_n = !on;
    if (!on)
      mosi = !mosi;
    #100;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      #62.5 sck = 1'b1;
      rx[i] = miso;
      #62.5 sck = 1'b0;
    end
    #62.5;
  endtask
endmodule

// ===== testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic debug_halt = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] pad_out;
  logic [3:0] pad_oe;
  logic sck, mosi, ss_n, miso, irq, hit, wake_req, core_clk_req;
  logic [7:0] b, x, rx;
  logic [7:0] exp_q[$];
  int fails = 0;
  int checks_done = 0;
  always #2.5 sys_clk = !sys_clk;
  assign miso = pad_oe[0] ? pad_out[0] : !pad_out[0];
  ssp_top uut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pad_in({mosi, ss_n, sck, miso}),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .sleep_req(sleep_req),
    .debug_halt(debug_halt),
    .irq(irq),
    .wake_req(wake_req),
    .core_clk_req(core_clk_req)
  );
  ssp_mst_model m (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic irq_is(input logic v);
    repeat (3) @(posedge sys_clk);
    #1 chk({31'h0, irq}, {31'h0, v});
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Ten two-character frames take about 24 us
  initial
  begin
    #200000;
    fails++;
    stop_test;
  end
  initial
  begin
    void'($urandom(50));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h0E, 32'h1);
    rd(8'h09, 32'h0);
    wr(8'h0D, 32'h0);
    irq_is(1'b0);
    wr(8'h0D, 32'h7);
    irq_is(1'b1);
    wr(8'h0C, 32'h1);
    irq_is(1'b0);
    wr(8'h00, 32'h0230_0008);
    wr(8'h04, 32'h0002_0000);
    wr(8'h14, 32'h000F_005A);
    wr(8'h00, 32'h0230_000A);
    rd(8'h10, 32'h8000);
    repeat (5) @(posedge sys_clk);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      b = i[0] ? {4'h5, 4'($urandom)} : 8'($urandom);
      x = 8'($urandom);
      hit = ((b ^ 8'h5A) & 8'hF0) == 8'h00;
      if (hit)
      begin
        exp_q.push_back(b);
        exp_q.push_back(x);
      end
      m.sel(1'b1);
      m.xfer(b, rx);
      rd(8'h0E, {29'h0, hit, 2'h1});
      if (hit)
        rd(8'h18, {24'h0, exp_q.pop_front()});
      m.xfer(x, rx);
      chk({31'h0, pad_oe[0]}, {31'h0, hit});
      // Without preload the address character goes back out first
      if (hit)
      begin
        chk({24'h0, rx}, {24'h0, b});
        rd(8'h18, {24'h0, exp_q.pop_front()});
      end
      m.sel(1'b0);
      rd(8'h0E, {30'h0, hit, 1'b1});
      wr(8'h0E, 32'h2);
    end
    // Asleep without keep-running: a matching frame is dropped
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    m.sel(1'b1);
    m.xfer(8'h5A, rx);
    m.xfer(8'h3C, rx);
    chk({31'h0, pad_oe[0]}, 32'h0);
    chk({30'h0, wake_req, core_clk_req}, 32'h0);
    m.sel(1'b0);
    rd(8'h0E, 32'h1);
    stop_test;
  end
endmodule
